//--- design/afipc_regs.v
// accelerometer fifo, interrupt pin, self-test and power configuration bank
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "afipc_map.vh"

module afipc_regs (
  input  wire        mclk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // raw samples from the sensing core
  input  wire        sample_valid,
  input  wire [15:0] sample_x,
  input  wire [15:0] sample_y,
  input  wire [15:0] sample_z,
  input  wire        data_read_ack,
  // corrected samples
  output reg  [15:0] acc_data_x,
  output reg  [15:0] acc_data_y,
  output reg  [15:0] acc_data_z,
  output reg         acc_data_ready,
  output reg         acquisition_run,
  // fifo datapath interface
  input  wire [12:0] fifo_fill_level,
  input  wire [12:0] fifo_watermark,
  input  wire        fifo_full,
  output reg         fifo_mode_fifo,
  output reg         fifo_store_sample,
  output reg         fifo_store_pin_one_evt,
  output reg         fifo_store_pin_two_evt,
  // interrupt pins, oe low while driving
  input  wire        irq_pin_one_in,
  output reg         irq_pin_one_out,
  output reg         irq_pin_one_oe_n,
  input  wire        irq_pin_two_in,
  output reg         irq_pin_two_out,
  output reg         irq_pin_two_oe_n
);

  //========================================================================
  // register state
  reg [7:0] fifo_mode_config_ff;
  reg [7:0] fifo_source_select_ff;
  reg [7:0] irq_pin_one_config_ff;
  reg [7:0] irq_pin_two_config_ff;
  reg [7:0] irq_event_routing_ff;
  reg [7:0] self_test_control_ff;
  reg [7:0] power_save_config_ff;
  reg [7:0] power_switch_control_ff;
  reg       pready_ff;

  //========================================================================
  // apb decode
  // one wait state: the second access cycle answers with registered data
  wire       acc_phase = psel & penable;
  wire       addr_ok   = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
  wire [7:0] idx       = paddr[9:2];
  reg        hit;
  reg  [7:0] rd_byte;

  always @* begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `AFIPC_IDX_FIFO_MODE:  rd_byte = fifo_mode_config_ff;
      `AFIPC_IDX_FIFO_SRC:   rd_byte = fifo_source_select_ff;
      `AFIPC_IDX_PIN_ONE:    rd_byte = irq_pin_one_config_ff;
      `AFIPC_IDX_PIN_TWO:    rd_byte = irq_pin_two_config_ff;
      `AFIPC_IDX_ROUTING:    rd_byte = irq_event_routing_ff;
      `AFIPC_IDX_SELF_TEST:  rd_byte = self_test_control_ff;
      `AFIPC_IDX_PWR_SAVE:   rd_byte = power_save_config_ff;
      `AFIPC_IDX_PWR_SWITCH: rd_byte = power_switch_control_ff;
      default:               hit     = 1'b0;
    endcase
    if (!addr_ok) begin
      hit = 1'b0;
    end
  end

  wire       valid_hit = hit & addr_ok;
  wire       wr_go     = acc_phase & pready_ff & pwrite & valid_hit;
  wire [7:0] wb        = pwdata[7:0];

  assign pready  = pready_ff;
  assign pslverr = pready_ff & ~valid_hit;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      pready_ff <= acc_phase & ~pready_ff;
      if (acc_phase & ~pready_ff) begin
        prdata <= (~pwrite & valid_hit) ? {24'h00_0000, rd_byte} :
                  32'h0000_0000;
      end
    end
  end

  //========================================================================
  // reserved code filter for byte-coded registers
  wire st_code_ok = (wb == `AFIPC_ST_OFF) | (wb == `AFIPC_ST_POS) |
                    (wb == `AFIPC_ST_NEG);                           // R12
  wire ps_code_ok = (wb == `AFIPC_PWR_SUSPEND) |
                    (wb == `AFIPC_PWR_ACTIVE);                       // R15
  wire sw_code_ok = (wb == `AFIPC_SW_OFF) | (wb == `AFIPC_SW_ON);    // R16

  //========================================================================
  // register writes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fifo_mode_config_ff     <= `AFIPC_RST_FIFO_MODE;               // R1 R2
      fifo_source_select_ff   <= `AFIPC_RST_FIFO_SRC;                // R2 R3
      irq_pin_one_config_ff   <= `AFIPC_RST_PIN_CFG;                 // R6
      irq_pin_two_config_ff   <= `AFIPC_RST_PIN_CFG;                 // R8
      irq_event_routing_ff    <= `AFIPC_RST_ROUTING;
      self_test_control_ff    <= `AFIPC_RST_SELF_TEST;
      power_save_config_ff    <= `AFIPC_RST_PWR_SAVE;                // R15
      power_switch_control_ff <= `AFIPC_RST_PWR_SWITCH;              // R16
    end else if (wr_go) begin
      case (idx)
        `AFIPC_IDX_FIFO_MODE:
          fifo_mode_config_ff <= wb & `AFIPC_MSK_FIFO_MODE;
        `AFIPC_IDX_FIFO_SRC:
          fifo_source_select_ff <= wb & `AFIPC_MSK_FIFO_SRC;
        `AFIPC_IDX_PIN_ONE:
          irq_pin_one_config_ff <= wb & `AFIPC_MSK_PIN_CFG;
        `AFIPC_IDX_PIN_TWO:
          irq_pin_two_config_ff <= wb & `AFIPC_MSK_PIN_CFG;
        `AFIPC_IDX_ROUTING:
          irq_event_routing_ff <= wb & `AFIPC_MSK_ROUTING;
        // self-test only leaves on an explicit off write
        `AFIPC_IDX_SELF_TEST: begin
          if (st_code_ok) begin
            self_test_control_ff <= wb;                              // R14 R20
          end
        end
        `AFIPC_IDX_PWR_SAVE: begin
          if (ps_code_ok) begin
            power_save_config_ff <= wb;                              // R20
          end
        end
        `AFIPC_IDX_PWR_SWITCH: begin
          if (sw_code_ok) begin
            power_switch_control_ff <= wb;                           // R17 R20
          end
        end
        default: begin
        end
      endcase
    end
  end

  //========================================================================
  // operating state
  wire acc_on   = (power_switch_control_ff == `AFIPC_SW_ON);         // R16
  wire acc_act  = (power_save_config_ff == `AFIPC_PWR_ACTIVE);       // R15
  wire run      = acc_on & acc_act;
  wire st_pos   = (self_test_control_ff == `AFIPC_ST_POS);           // R12
  wire st_neg   = (self_test_control_ff == `AFIPC_ST_NEG);           // R12
  wire take     = sample_valid & run;                                // R15

  //========================================================================
  // sample path with self-test offset
  // the offset wraps like the core's two's complement adder; no clipping
  function [15:0] st_apply;
    input [15:0] raw;
    input        pos;
    input        neg;
    begin
      if (pos) begin
        st_apply = raw + `AFIPC_ST_OFFSET;                           // R13
      end else if (neg) begin
        st_apply = raw - `AFIPC_ST_OFFSET;                           // R13
      end else begin
        st_apply = raw;
      end
    end
  endfunction

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_data_x        <= 16'h0000;
      acc_data_y        <= 16'h0000;
      acc_data_z        <= 16'h0000;
      acc_data_ready    <= 1'b0;
      acquisition_run   <= 1'b0;
      fifo_mode_fifo    <= 1'b0;
      fifo_store_sample <= 1'b0;
    end else begin
      acquisition_run <= run;
      fifo_mode_fifo  <= fifo_mode_config_ff[`AFIPC_B_MODE_FIFO];    // R1
      fifo_store_sample <= take &
        fifo_source_select_ff[`AFIPC_B_SRC_ACC];                     // R3
      if (take) begin
        acc_data_x <= st_apply(sample_x, st_pos, st_neg);
        acc_data_y <= st_apply(sample_y, st_pos, st_neg);
        acc_data_z <= st_apply(sample_z, st_pos, st_neg);
      end
      // a new sample wins over an acknowledge in the same cycle
      if (take) begin
        acc_data_ready <= 1'b1;
      end else if (data_read_ack) begin
        acc_data_ready <= 1'b0;
      end
    end
  end

  //========================================================================
  // events
  wire ev_ready = acc_data_ready;
  wire ev_wm    = (fifo_fill_level >= fifo_watermark);               // R18
  wire ev_full  = fifo_full;
  wire [2:0] ev_vec = {ev_ready, ev_wm, ev_full};

  //========================================================================
  // per-pin logic: input capture and output drive
  wire [7:0] pin_cfg   [0:1];
  wire [1:0] pin_in;
  wire [1:0] pin_drive;
  wire [1:0] pin_oe_n;
  wire [1:0] pin_evt;
  wire [1:0] src_en;

  assign pin_cfg[0] = irq_pin_one_config_ff;
  assign pin_cfg[1] = irq_pin_two_config_ff;
  assign pin_in     = {irq_pin_two_in, irq_pin_one_in};
  assign src_en     = {fifo_source_select_ff[`AFIPC_B_SRC_PIN_TWO],
                       fifo_source_select_ff[`AFIPC_B_SRC_PIN_ONE]};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      reg        s1_ff;
      reg        s2_ff;
      reg        s3_ff;
      reg        lvl_ff;
      reg        lvl_d_ff;
      wire       pol    = pin_cfg[g][`AFIPC_B_PIN_LVL];              // R7 R9
      wire       od     = pin_cfg[g][`AFIPC_B_PIN_OD];               // R7 R9
      wire       in_en  = pin_cfg[g][`AFIPC_B_PIN_IN];               // R6 R8
      wire       out_en = pin_cfg[g][`AFIPC_B_PIN_OUT];              // R6 R8
      wire [2:0] route  = (g == 0) ?
        irq_event_routing_ff[`AFIPC_B_RT_ONE_LO +: 3] :              // R10
        irq_event_routing_ff[`AFIPC_B_RT_TWO_LO +: 3];               // R11
      wire       assert_evt = |(route & ev_vec);                     // R19
      wire       level  = assert_evt ? pol : ~pol;                   // R19
      wire       active_in = (lvl_ff == pol);

      // three-stage capture; a level counts once stages two and three agree
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_ff    <= 1'b0;
          s2_ff    <= 1'b0;
          s3_ff    <= 1'b0;
          lvl_ff   <= 1'b0;
          lvl_d_ff <= 1'b0;
        end else begin
          s1_ff    <= pin_in[g];
          s2_ff    <= s1_ff;
          s3_ff    <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
          lvl_d_ff <= lvl_ff;
        end
      end

      // edge into the programmed active level, only while input enabled
      assign pin_evt[g] = in_en & src_en[g] & active_in &
                          (lvl_ff != lvl_d_ff);                      // R4 R5
      // open-drain only pulls low and releases otherwise
      assign pin_drive[g] = od ? 1'b0 : level;                       // R7 R9
      assign pin_oe_n[g]  = ~out_en | (od & level);                  // R6 R8
    end
  endgenerate

  //========================================================================
  // registered pin and fifo event outputs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_pin_one_out        <= 1'b0;
      irq_pin_one_oe_n       <= 1'b1;
      irq_pin_two_out        <= 1'b0;
      irq_pin_two_oe_n       <= 1'b1;
      fifo_store_pin_one_evt <= 1'b0;
      fifo_store_pin_two_evt <= 1'b0;
    end else begin
      irq_pin_one_out        <= pin_drive[0];                        // R19
      irq_pin_one_oe_n       <= pin_oe_n[0];
      irq_pin_two_out        <= pin_drive[1];                        // R19
      irq_pin_two_oe_n       <= pin_oe_n[1];
      fifo_store_pin_one_evt <= pin_evt[0];                          // R4
      fifo_store_pin_two_evt <= pin_evt[1];                          // R5
    end
  end

endmodule // afipc_regs
`default_nettype wire

//--- design/afipc_map.vh
// register map, field positions, codes and reset values of the accel config bank
//==========================================================================
// Functional notes
// R1 - mode register bit 0 picks stream (0) or fifo (1) policy, reset 0
// R2 - software keeps mode bit 1 and source bit 4 at one; both reset one
// R3 - source bit 6 set lets accelerometer samples be stored in the fifo
// R4 - source bit 3 stores pin one input events; pin one must be input
// R5 - source bit 2 stores pin two input events; pin two must be input
// R6 - pin one config bit 4 enables input, bit 3 enables output, reset 0
// R7 - pin one bit 2 picks push-pull/open-drain, bit 1 picks active level
// R8 - pin two config bit 4 enables input, bit 3 enables output, reset 0
// R9 - pin two bit 2 picks push-pull/open-drain, bit 1 picks active level
// R10 - routing bits 2,1,0 send ready, watermark, full events to pin one
// R11 - routing bits 6,5,4 send ready, watermark, full events to pin two
// R12 - self-test byte: 00 off, 0d positive, 09 negative excitation
// R13 - active self-test adds a steady offset to the output data
// R14 - self-test stays on until software writes the off code
// R15 - power save byte 03 suspends (reset), 00 runs; suspend halts capture
// R16 - power switch byte 00 means off (reset), 04 means on
// R17 - after reset software writes the on code before data appears
// R18 - watermark event active while fill level in bytes reaches watermark
// R19 - output pin asserts with programmed level and drive on any routed event
// R20 - unlisted self-test and power codes are ignored, state unchanged
`ifndef AFIPC_MAP_VH
`define AFIPC_MAP_VH

//==========================================================================
// register indexes (byte address is four times the index)
`define AFIPC_IDX_FIFO_MODE   8'h48
`define AFIPC_IDX_FIFO_SRC    8'h49
`define AFIPC_IDX_PIN_ONE     8'h53
`define AFIPC_IDX_PIN_TWO     8'h54
`define AFIPC_IDX_ROUTING     8'h58
`define AFIPC_IDX_SELF_TEST   8'h6d
`define AFIPC_IDX_PWR_SAVE    8'h7c
`define AFIPC_IDX_PWR_SWITCH  8'h7d

//==========================================================================
// reset values
`define AFIPC_RST_FIFO_MODE   8'h02
`define AFIPC_RST_FIFO_SRC    8'h10
`define AFIPC_RST_PIN_CFG     8'h00
`define AFIPC_RST_ROUTING     8'h00
`define AFIPC_RST_SELF_TEST   8'h00
`define AFIPC_RST_PWR_SAVE    8'h03
`define AFIPC_RST_PWR_SWITCH  8'h00

//==========================================================================
// writable bits, reserved bits read as zero
`define AFIPC_MSK_FIFO_MODE   8'h03
`define AFIPC_MSK_FIFO_SRC    8'h7c
`define AFIPC_MSK_PIN_CFG     8'h1e
`define AFIPC_MSK_ROUTING     8'h77

//==========================================================================
// field positions
`define AFIPC_B_MODE_FIFO     0
`define AFIPC_B_SRC_ACC       6
`define AFIPC_B_SRC_PIN_ONE   3
`define AFIPC_B_SRC_PIN_TWO   2
`define AFIPC_B_PIN_IN        4
`define AFIPC_B_PIN_OUT       3
`define AFIPC_B_PIN_OD        2
`define AFIPC_B_PIN_LVL       1
`define AFIPC_B_RT_ONE_LO     0
`define AFIPC_B_RT_TWO_LO     4

//==========================================================================
// codes
`define AFIPC_ST_OFF          8'h00
`define AFIPC_ST_POS          8'h0d
`define AFIPC_ST_NEG          8'h09
`define AFIPC_PWR_SUSPEND     8'h03
`define AFIPC_PWR_ACTIVE      8'h00
`define AFIPC_SW_OFF          8'h00
`define AFIPC_SW_ON           8'h04

//==========================================================================
// self-test excitation added to each axis
`define AFIPC_ST_OFFSET       16'h0100

`endif

//--- bench/afipc_props.sv
// concurrent checks on the ports of the accel configuration bank
`timescale 1ns/1ps
`default_nettype none
module afipc_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sample_valid,
  input wire logic        data_read_ack,
  input wire logic [15:0] acc_data_x,
  input wire logic        acc_data_ready,
  input wire logic        acquisition_run,
  input wire logic        fifo_mode_fifo,
  input wire logic        fifo_store_sample
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  //==========================================================================
  // bus cycle steps
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_wait; s_setup ##1 (psel && penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  property p_align; s_done ##0 (paddr[1:0] != 2'b00) |-> pslverr; endproperty
  a_align: assert property (p_align) else $error("misaligned access not refused");
  property p_errdata; pslverr |-> pready && prdata == 32'h0; endproperty
  a_errdata: assert property (p_errdata) else $error("refusal with data");
  // mode output follows the stored policy bit two cycles on
  property p_mode; s_done ##0 (pwrite && paddr == 12'h120 && !pslverr)
    |-> ##2 fifo_mode_fifo == $past(pwdata[0], 2); endproperty
  a_mode: assert property (p_mode) else $error("fifo policy not applied");
  //==========================================================================
  // sample path
  // acquisition_run trails the register state by one cycle, so the state
  // that decided a sample is read one cycle after sample_valid
  property p_drop;
    sample_valid ##1 !acquisition_run |-> !fifo_store_sample;
  endproperty
  a_drop: assert property (p_drop) else $error("sample taken while halted");
  property p_take;
    sample_valid ##1 acquisition_run |-> acc_data_ready;
  endproperty
  a_take: assert property (p_take) else $error("sample not taken");
  property p_hold; !sample_valid |=> $stable(acc_data_x); endproperty
  a_hold: assert property (p_hold) else $error("output moved without sample");
  property p_store; fifo_store_sample |-> acc_data_ready && $past(sample_valid); endproperty
  a_store: assert property (p_store) else $error("store without sample");
  property p_ack; data_read_ack && !sample_valid |=> !acc_data_ready; endproperty
  a_ack: assert property (p_ack) else $error("ready not cleared");
endmodule // afipc_props

bind afipc_regs afipc_props afipc_props_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .sample_valid(sample_valid), .data_read_ack(data_read_ack),
  .acc_data_x(acc_data_x), .acc_data_ready(acc_data_ready),
  .acquisition_run(acquisition_run), .fifo_mode_fifo(fifo_mode_fifo),
  .fifo_store_sample(fifo_store_sample)
);
`default_nettype wire

//--- bench/afipc_host.sv
// apb host model that reaches the register bank
`timescale 1ns/1ps
`default_nettype none
module afipc_host (
  input  wire logic        mclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
  end
  //==========================================================================
  // one transfer; released address and data are inverted so a slave that
  // looks at them outside a request sees no stale value
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] r,
                      output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~{24'h0, d};
  endtask
endmodule // afipc_host
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the accel configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rst = 1'b1, psel, penable, pwrite, pready, pslverr, e;
  logic        sv = 1'b0, ack = 1'b0, full = 1'b0, run, rdy, st, mf;
  logic        p1o, p1n, p2o, p2n, e1, e2, ev1, ev2;
  logic        pi1 = 1'b0, pi2 = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, seed = 32'd59419;
  logic [15:0] sx = 16'h0, sy = 16'h0, sz = 16'h0, ax, ay, az;
  logic [12:0] fill = 13'h0, wm = 13'h0;
  logic [7:0]  d;
  logic [3:0]  c1, c2;
  logic [15:0] lx;
  int          fail_count = 0, total_checks = 0, cyc = 0, k;
  logic [7:0]  idx [8] = '{8'h48, 8'h49, 8'h53, 8'h54, 8'h58, 8'h6d, 8'h7c, 8'h7d};
  logic [7:0]  rv [8] = '{8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0]  msk [5] = '{8'h03, 8'h7c, 8'h1e, 8'h1e, 8'h77};
  logic [7:0]  stc [4] = '{8'h0d, 8'h09, 8'h0c, 8'h00};
  logic [15:0] sto [4] = '{16'h0100, 16'hff00, 16'hff00, 16'h0000};

  afipc_regs afipc_regs_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .sample_valid(sv), .sample_x(sx), .sample_y(sy),
    .sample_z(sz), .data_read_ack(ack), .acc_data_x(ax), .acc_data_y(ay),
    .acc_data_z(az), .acc_data_ready(rdy), .acquisition_run(run),
    .fifo_fill_level(fill), .fifo_watermark(wm), .fifo_full(full),
    .fifo_mode_fifo(mf), .fifo_store_sample(st), .fifo_store_pin_one_evt(ev1),
    .fifo_store_pin_two_evt(ev2), .irq_pin_one_in(pi1), .irq_pin_one_out(p1o),
    .irq_pin_one_oe_n(p1n), .irq_pin_two_in(pi2), .irq_pin_two_out(p2o),
    .irq_pin_two_oe_n(p2n));
  afipc_host afipc_host_inst (
    .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  //==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    afipc_host_inst.xfer(1'b1, {2'b00, i, 2'b00}, v, rd, e);
  endtask
  task automatic rr(input logic [7:0] i, input logic [7:0] x);
    afipc_host_inst.xfer(1'b0, {2'b00, i, 2'b00}, 8'h00, rd, e);
    chk({e, rd}, {25'h0, x});
  endtask
  task automatic smp(input logic [15:0] x);
    @(posedge mclk);
    sv <= 1'b1;
    sx <= x;
    sy <= ~x;
    sz <= x ^ 16'h5a5a;
    @(posedge mclk);
    sv <= 1'b0;
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      complete_run();
    end
  end
  //==========================================================================
  // scenarios
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rr(idx[i], rv[i]);
    afipc_host_inst.xfer(1'b0, 12'h004, 8'h00, rd, e);
    chk({e, rd}, {1'b1, 32'h0});
    afipc_host_inst.xfer(1'b1, 12'h121, 8'h01, rd, e);
    chk({e, rd}, {1'b1, 32'h0});
    rr(8'h48, 8'h02);
    $display("test reset and refusal done");
    for (int n = 0; n < 24; n++) begin
      k = rnd() % 5;
      r = rnd();
      d = r[7:0] | (k == 0 ? 8'h02 : (k == 1 ? 8'h10 : 8'h00));
      wr(idx[k], d);
      rr(idx[k], d & msk[k]);
      if (k == 0) chk(mf, d[0]);
    end
    $display("test read back done");
    wr(8'h49, 8'h50);
    smp(16'h1234);
    chk({run, rdy, st}, 3'b000);
    wr(8'h7d, 8'h05);
    rr(8'h7d, 8'h00);
    wr(8'h7d, 8'h04);
    wr(8'h7c, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(8'h6d, stc[i]);
      smp(r[15:0]);
      chk({run, rdy, st, ax, ay, az},
          {3'b111, r[15:0] + sto[i], ~r[15:0] + sto[i],
           (r[15:0] ^ 16'h5a5a) + sto[i]});
      lx = r[15:0] + sto[i];
    end
    $display("test power and self-test done");
    wr(8'h53, 8'h0a);
    wr(8'h54, 8'h0c);
    for (int n = 0; n < 16; n++) begin
      r = rnd();
      wr(8'h58, r[7:0] & 8'h77);
      @(posedge mclk);
      wm <= r[20:8];
      fill <= r[20:8] + {11'h0, r[22:21]} - 13'd1;
      full <= r[23];
      repeat (3) @(posedge mclk);
      #1;
      e1 = r[2] | (r[1] & (fill >= wm)) | (r[0] & full);
      e2 = r[6] | (r[5] & (fill >= wm)) | (r[4] & full);
      chk({p1n, p1o, p2o, p2n}, {1'b0, e1, 1'b0, ~e2});
    end
    $display("test pin drive done");
    // pin one active high, pin two active low, both inputs with store on
    wr(8'h53, 8'h12);
    wr(8'h54, 8'h10);
    wr(8'h49, 8'h5c);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      pi1 <= (p == 0);
      pi2 <= (p == 0);
      c1 = 4'h0;
      c2 = 4'h0;
      repeat (8) begin
        @(posedge mclk);
        #1;
        c1 = c1 + {3'b000, ev1};
        c2 = c2 + {3'b000, ev2};
      end
      chk({c1, c2}, (p == 0) ? 8'h10 : 8'h01);
      chk({p1n, p2n}, 2'b11);
    end
    $display("test pin capture done");
    @(posedge mclk);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    #1;
    chk(rdy, 1'b0);
    wr(8'h7c, 8'h03);
    smp(16'h0bad);
    chk({run, rdy, st, ax}, {3'b000, lx});
    $display("test suspend done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
